// ===== src/l2bw_arbiter.sv
// Purpose: L2 bandwidth manager between CPU and DMA requests
// Assumes: Requests come from logic on CLK, held until granted
// Notes: Each grant pulse is one L2 slice
//
// The AHB-Lite interface to the registers is this design's own decision.

`timescale 1ns/10ps

module l2bw_arbiter (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // AHB-Lite slave
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic [1:0] HRESP,
  // Requests
  input wire logic CPU_REQ,
  input wire logic INTERNAL_TRANSFER_ENGINE_REQ,
  input wire logic SLAVE_TRANSFER_PORT_REQ,
  input wire logic SLAVE_TRANSFER_PORT_MST,
  input wire logic SLAVE_TRANSFER_PORT_DONE,
  // Grants
  output logic CPU_GNT,
  output logic INTERNAL_TRANSFER_ENGINE_GNT,
  output logic SLAVE_TRANSFER_PORT_GNT
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [31:0] src;
    logic [31:0] dst;
    logic [31:0] cnt;
    logic [31:0] cpu_arb;
    logic [31:0] dma_arb;
    logic [31:0] mst0;
    logic [31:0] mst1;
    l2bw_pkg::l2bw_bus_e bus;
    logic [31:0] addr;
    logic [31:0] rdata;
    logic rdy;
    logic [l2bw_pkg::REQ_N-1:0] gnt;
    logic share;
    logic rr;
  } l2bw_state_s;

  l2bw_state_s s_q;
  l2bw_state_s s_d;

  logic [l2bw_pkg::REQ_N-1:0] req;
  logic [l2bw_pkg::REQ_N-1:0] expd;
  logic [l2bw_pkg::REQ_N-1:0][l2bw_pkg::WAIT_W-1:0] thr;
  logic [l2bw_pkg::REQ_N-1:0][l2bw_pkg::WAIT_W-1:0] ctr;
  logic [l2bw_pkg::PRI_W-1:0] cpu_pri;
  logic [l2bw_pkg::PRI_W-1:0] internal_transfer_engine_pri;
  logic [l2bw_pkg::PRI_W-1:0] slave_transfer_port_pri;
  logic [l2bw_pkg::PRI_W-1:0] dma_pri;
  logic dma_req;
  logic pick_slave_transfer_port;
  logic dma_tie;
  logic defect;
  logic cpu_exp;
  logic dma_exp;
  logic take_cpu;
  logic addr_ok;

  // ----------------------------------------
  // Priority sources
  // ----------------------------------------
  assign cpu_pri = l2bw_pkg::l2bw_pri(s_q.cpu_arb, l2bw_pkg::ARB_PRI_LSB);
  assign internal_transfer_engine_pri = l2bw_pkg::l2bw_pri(s_q.cnt, l2bw_pkg::CNT_PRI_LSB);
  // A drained port drops to seven whatever its master asked for
  assign slave_transfer_port_pri = SLAVE_TRANSFER_PORT_DONE ? l2bw_pkg::PRI_DRAINED :
    l2bw_pkg::l2bw_pri(SLAVE_TRANSFER_PORT_MST ? s_q.mst1 : s_q.mst0, l2bw_pkg::MST_PORT_LSB);
  assign defect = s_q.cpu_arb[l2bw_pkg::ARB_DEFECT_BIT];

  assign req[l2bw_pkg::REQ_CPU] = CPU_REQ;
  assign req[l2bw_pkg::REQ_INTERNAL_TRANSFER_ENGINE] = INTERNAL_TRANSFER_ENGINE_REQ;
  assign req[l2bw_pkg::REQ_SLAVE_TRANSFER_PORT] = SLAVE_TRANSFER_PORT_REQ;
  assign thr[l2bw_pkg::REQ_CPU] = l2bw_pkg::l2bw_wait(s_q.cpu_arb);
  assign thr[l2bw_pkg::REQ_INTERNAL_TRANSFER_ENGINE] = l2bw_pkg::l2bw_wait(s_q.dma_arb);
  assign thr[l2bw_pkg::REQ_SLAVE_TRANSFER_PORT] = l2bw_pkg::l2bw_wait(s_q.dma_arb);

  // ----------------------------------------
  // Contention counters
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < l2bw_pkg::REQ_N; gi++) begin : g_ctr
      l2bw_wait_ctr u_ctr (
        .CLK(CLK),
        .RST(RST),
        .req(req[gi]),
        .gnt(s_d.gnt[gi]),
        .thr(thr[gi]),
        .cnt(ctr[gi]),
        .expired(expd[gi])
      );
    end
  endgenerate

  l2bw_dma_pick u_pick (
    .internal_transfer_engine_req(INTERNAL_TRANSFER_ENGINE_REQ),
    .slave_transfer_port_req(SLAVE_TRANSFER_PORT_REQ),
    .internal_transfer_engine_pri(internal_transfer_engine_pri),
    .slave_transfer_port_pri(slave_transfer_port_pri),
    .internal_transfer_engine_exp(expd[l2bw_pkg::REQ_INTERNAL_TRANSFER_ENGINE]),
    .slave_transfer_port_exp(expd[l2bw_pkg::REQ_SLAVE_TRANSFER_PORT]),
    .rr(s_q.rr),
    .req(dma_req),
    .pick_slave_transfer_port(pick_slave_transfer_port),
    .tie(dma_tie),
    .pri(dma_pri)
  );

  // ----------------------------------------
  // Class decision
  // ----------------------------------------
  assign cpu_exp = expd[l2bw_pkg::REQ_CPU];
  // In defect mode a waiting DMA cannot overtake a lower or equal CPU
  assign dma_exp = (expd[l2bw_pkg::REQ_INTERNAL_TRANSFER_ENGINE] || expd[l2bw_pkg::REQ_SLAVE_TRANSFER_PORT]) &&
    !(defect && cpu_pri >= dma_pri);

  always_comb begin
    if (!CPU_REQ) begin
      take_cpu = 1'b0;
    end else if (!dma_req || cpu_exp) begin
      take_cpu = 1'b1;
    end else if (dma_exp) begin
      take_cpu = 1'b0;
    end else if (cpu_pri < dma_pri) begin
      take_cpu = 1'b1;
    end else if (defect) begin
      take_cpu = 1'b1;
    end else if (cpu_pri == dma_pri) begin
      take_cpu = s_q.share;
    end else begin
      take_cpu = 1'b0;
    end
  end

  assign addr_ok = HSEL && HREADY && HTRANS[1];

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.rdy = 1'b1;
    // Data phase of a write lands before any read is sampled
    if (s_q.bus == l2bw_pkg::L2BW_BUS_WRITE) begin
      case (s_q.addr)
        l2bw_pkg::ADDR_SRC: begin
          s_d.src = HWDATA;
        end
        l2bw_pkg::ADDR_DST: begin
          s_d.dst = HWDATA;
        end
        l2bw_pkg::ADDR_CNT: begin
          s_d.cnt = HWDATA;
        end
        l2bw_pkg::ADDR_CPU_ARB: begin
          s_d.cpu_arb = HWDATA;
        end
        l2bw_pkg::ADDR_DMA_ARB: begin
          s_d.dma_arb = HWDATA;
        end
        l2bw_pkg::ADDR_MST0: begin
          s_d.mst0 = HWDATA;
        end
        l2bw_pkg::ADDR_MST1: begin
          s_d.mst1 = HWDATA;
        end
        default: begin
        end
      endcase
    end
    if (addr_ok) begin
      s_d.bus = HWRITE ? l2bw_pkg::L2BW_BUS_WRITE : l2bw_pkg::L2BW_BUS_READ;
    end else begin
      s_d.bus = l2bw_pkg::L2BW_BUS_IDLE;
    end
    s_d.addr = HADDR;
    // Read word sampled from the updated copy, so write then read is coherent
    s_d.rdata = '0;
    if (addr_ok && !HWRITE) begin
      case (HADDR)
        l2bw_pkg::ADDR_SRC: begin
          s_d.rdata = s_d.src;
        end
        l2bw_pkg::ADDR_DST: begin
          s_d.rdata = s_d.dst;
        end
        l2bw_pkg::ADDR_CNT: begin
          s_d.rdata = s_d.cnt;
        end
        l2bw_pkg::ADDR_CPU_ARB: begin
          s_d.rdata = s_d.cpu_arb;
        end
        l2bw_pkg::ADDR_DMA_ARB: begin
          s_d.rdata = s_d.dma_arb;
        end
        l2bw_pkg::ADDR_MST0: begin
          s_d.rdata = s_d.mst0;
        end
        l2bw_pkg::ADDR_MST1: begin
          s_d.rdata = s_d.mst1;
        end
        l2bw_pkg::ADDR_STATUS: begin
          s_d.rdata[l2bw_pkg::STAT_GNT_LSB +: l2bw_pkg::REQ_N] = s_q.gnt;
          s_d.rdata[l2bw_pkg::STAT_CPU_CTR_LSB +: l2bw_pkg::WAIT_W] = ctr[l2bw_pkg::REQ_CPU];
          s_d.rdata[l2bw_pkg::STAT_INTERNAL_TRANSFER_ENGINE_CTR_LSB +: l2bw_pkg::WAIT_W] = ctr[l2bw_pkg::REQ_INTERNAL_TRANSFER_ENGINE];
          s_d.rdata[l2bw_pkg::STAT_SLAVE_TRANSFER_PORT_CTR_LSB +: l2bw_pkg::WAIT_W] = ctr[l2bw_pkg::REQ_SLAVE_TRANSFER_PORT];
        end
        default: begin
        end
      endcase
    end
    // One class per slice
    s_d.gnt = '0;
    if (take_cpu) begin
      s_d.gnt[l2bw_pkg::REQ_CPU] = 1'b1;
    end else if (dma_req) begin
      s_d.gnt[pick_slave_transfer_port ? l2bw_pkg::REQ_SLAVE_TRANSFER_PORT : l2bw_pkg::REQ_INTERNAL_TRANSFER_ENGINE] = 1'b1;
    end
    if (CPU_REQ && dma_req && cpu_pri == dma_pri && !cpu_exp && !dma_exp) begin
      s_d.share = !s_q.share;
    end
    if (!take_cpu && dma_tie) begin
      s_d.rr = !s_q.rr;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s_q.src <= l2bw_pkg::RST_DATA;
      s_q.dst <= l2bw_pkg::RST_DATA;
      s_q.cnt <= l2bw_pkg::RST_CNT;
      s_q.cpu_arb <= l2bw_pkg::RST_CPU_ARB;
      s_q.dma_arb <= l2bw_pkg::RST_DMA_ARB;
      s_q.mst0 <= l2bw_pkg::RST_MST;
      s_q.mst1 <= l2bw_pkg::RST_MST;
      s_q.bus <= l2bw_pkg::L2BW_BUS_IDLE;
      s_q.addr <= '0;
      s_q.rdata <= '0;
      s_q.rdy <= 1'b1;
      s_q.gnt <= '0;
      s_q.share <= 1'b0;
      s_q.rr <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign HRDATA = s_q.rdata;
  assign HREADYOUT = s_q.rdy;
  assign HRESP = l2bw_pkg::HRESP_OKAY;
  assign CPU_GNT = s_q.gnt[l2bw_pkg::REQ_CPU];
  assign INTERNAL_TRANSFER_ENGINE_GNT = s_q.gnt[l2bw_pkg::REQ_INTERNAL_TRANSFER_ENGINE];
  assign SLAVE_TRANSFER_PORT_GNT = s_q.gnt[l2bw_pkg::REQ_SLAVE_TRANSFER_PORT];

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  default clocking cb @(posedge CLK);
  endclocking
  default disable iff (RST);

  a_one_class_grant: assert property ($onehot0({CPU_GNT, INTERNAL_TRANSFER_ENGINE_GNT, SLAVE_TRANSFER_PORT_GNT}))
    else $error("more than one grant");
  a_dma_source_req: assert property ((INTERNAL_TRANSFER_ENGINE_REQ || SLAVE_TRANSFER_PORT_REQ) && !CPU_REQ |=> INTERNAL_TRANSFER_ENGINE_GNT || SLAVE_TRANSFER_PORT_GNT)
    else $error("lone DMA request not granted");
  a_higher_pri_win: assert property (CPU_REQ && dma_req && !cpu_exp && !dma_exp && cpu_pri < dma_pri
    |=> CPU_GNT)
    else $error("higher CPU priority lost");
  a_counter_rises: assert property (CPU_REQ && !take_cpu && ctr[0] != l2bw_pkg::WAIT_MAX
    |=> ctr[0] == $past(ctr[0]) + 6'h01)
    else $error("contention counter did not count");
  a_counter_idle_zero: assert property (!INTERNAL_TRANSFER_ENGINE_REQ |=> ctr[1] == '0)
    else $error("counter not cleared");
  a_wait_slice: assert property (CPU_REQ && cpu_exp |=> CPU_GNT && ctr[0] == '0)
    else $error("expired request not served");
  a_dma_wait_slice: assert property (INTERNAL_TRANSFER_ENGINE_REQ && !SLAVE_TRANSFER_PORT_REQ && expd[1] && !cpu_exp && !defect
    |=> INTERNAL_TRANSFER_ENGINE_GNT)
    else $error("expired engine request not served");
  a_defect_cpu: assert property (defect && CPU_REQ && cpu_pri >= dma_pri |=> CPU_GNT)
    else $error("defect mode CPU did not win");
  a_drained_seven: assert property (SLAVE_TRANSFER_PORT_DONE |-> slave_transfer_port_pri == l2bw_pkg::PRI_DRAINED)
    else $error("drained port not at seven");
  a_cpu_pri_write: assert property (s_q.bus == l2bw_pkg::L2BW_BUS_WRITE && s_q.addr == l2bw_pkg::ADDR_CPU_ARB
    |=> cpu_pri == $past(HWDATA[2:0]))
    else $error("CPU priority not taken from register");
  a_internal_transfer_engine_pri_write: assert property (s_q.bus == l2bw_pkg::L2BW_BUS_WRITE && s_q.addr == l2bw_pkg::ADDR_CNT
    |=> internal_transfer_engine_pri == $past(HWDATA[31:29]))
    else $error("engine priority not taken from count word");

  c_cpu_starve: cover property (CPU_REQ && dma_exp ##1 (INTERNAL_TRANSFER_ENGINE_GNT || SLAVE_TRANSFER_PORT_GNT));
  c_equal_share: cover property (!defect && CPU_REQ && dma_req && cpu_pri == dma_pri ##1 CPU_GNT ##1 !CPU_GNT);
  c_status_read: cover property (addr_ok && !HWRITE && HADDR == l2bw_pkg::ADDR_STATUS);
  c_drained_port: cover property (SLAVE_TRANSFER_PORT_DONE && SLAVE_TRANSFER_PORT_REQ && CPU_REQ ##1 CPU_GNT);

  // ----------------------------------------
  // Grant, counter and priority checks
  // ----------------------------------------
  a_cpu_no_req: assert property (!CPU_REQ |=> !CPU_GNT)
    else $error("CPU granted without request");
  a_internal_transfer_engine_no_req: assert property (!INTERNAL_TRANSFER_ENGINE_REQ |=> !INTERNAL_TRANSFER_ENGINE_GNT)
    else $error("engine granted without request");
  a_slave_transfer_port_no_req: assert property (!SLAVE_TRANSFER_PORT_REQ |=> !SLAVE_TRANSFER_PORT_GNT)
    else $error("slave port granted without request");
  a_grant_clears: assert property (s_d.gnt[1] |=> ctr[1] == '0)
    else $error("counter not cleared on grant");
  a_cpu_idle_zero: assert property (!CPU_REQ |=> ctr[0] == '0)
    else $error("CPU counter not cleared");
  a_master_one_pri: assert property (!SLAVE_TRANSFER_PORT_DONE && SLAVE_TRANSFER_PORT_MST |-> slave_transfer_port_pri == s_q.mst1[6:4])
    else $error("slave port priority not from second master word");

endmodule : l2bw_arbiter

// ===== src/l2bw_pkg.sv
// Purpose: Shared constants and types of the L2 bandwidth arbiter
// Assumes: One clock, AHB-Lite register access
// Notes: Own registers sit beside the CPU arbitration word

package l2bw_pkg;

  // ----------------------------------------
  // Register byte addresses
  // ----------------------------------------
  localparam logic [31:0] ADDR_SRC = 32'h0182_0108;
  localparam logic [31:0] ADDR_DST = 32'h0182_010C;
  localparam logic [31:0] ADDR_CNT = 32'h0182_0110;
  localparam logic [31:0] ADDR_CPU_ARB = 32'h0184_1000;
  localparam logic [31:0] ADDR_DMA_ARB = 32'h0184_1004;
  localparam logic [31:0] ADDR_STATUS = 32'h0184_1008;
  localparam logic [31:0] ADDR_MST0 = 32'h01C4_003C;
  localparam logic [31:0] ADDR_MST1 = 32'h01C4_0040;

  // ----------------------------------------
  // Field layout
  // ----------------------------------------
  localparam int PRI_W = 3;
  localparam int WAIT_W = 6;
  localparam int ARB_PRI_LSB = 0;
  localparam int ARB_WAIT_LSB = 16;
  localparam int ARB_DEFECT_BIT = 31;
  localparam int CNT_PRI_LSB = 29;
  localparam int MST_PORT_LSB = 4;
  localparam int STAT_GNT_LSB = 0;
  localparam int STAT_CPU_CTR_LSB = 8;
  localparam int STAT_INTERNAL_TRANSFER_ENGINE_CTR_LSB = 16;
  localparam int STAT_SLAVE_TRANSFER_PORT_CTR_LSB = 24;

  // ----------------------------------------
  // Reset values and fixed levels
  // ----------------------------------------
  localparam logic [31:0] RST_DATA = 32'h0000_0000;
  localparam logic [31:0] RST_CPU_ARB = 32'h8010_0001;
  localparam logic [31:0] RST_DMA_ARB = 32'h0010_0000;
  localparam logic [31:0] RST_CNT = 32'h4000_0000;
  localparam logic [31:0] RST_MST = 32'h0000_0020;
  localparam logic [PRI_W-1:0] PRI_DRAINED = 3'h7;
  localparam logic [WAIT_W-1:0] WAIT_MAX = 6'h3F;
  localparam logic [1:0] HRESP_OKAY = 2'h0;

  // Requester slots
  localparam int REQ_CPU = 0;
  localparam int REQ_INTERNAL_TRANSFER_ENGINE = 1;
  localparam int REQ_SLAVE_TRANSFER_PORT = 2;
  localparam int REQ_N = 3;

  typedef enum logic [1:0] {
    L2BW_BUS_IDLE = 2'b00,
    L2BW_BUS_WRITE = 2'b01,
    L2BW_BUS_READ = 2'b11
  } l2bw_bus_e;

  function automatic logic [PRI_W-1:0] l2bw_pri(input logic [31:0] w, input int lsb);
    return w[lsb +: PRI_W];
  endfunction : l2bw_pri

  function automatic logic [WAIT_W-1:0] l2bw_wait(input logic [31:0] w);
    return w[ARB_WAIT_LSB +: WAIT_W];
  endfunction : l2bw_wait

endpackage : l2bw_pkg

// ===== src/l2bw_wait_ctr.sv
// Purpose: Contention-cycle counter of one requester
// Assumes: Grant is the arbiter decision of this cycle
// Notes: Threshold zero disables the forced slice

`timescale 1ns/10ps

module l2bw_wait_ctr (
  // Clock and reset
  input wire logic CLK,
  input wire logic RST,
  // Arbiter side
  input wire logic req,
  input wire logic gnt,
  input wire logic [l2bw_pkg::WAIT_W-1:0] thr,
  output logic [l2bw_pkg::WAIT_W-1:0] cnt,
  output logic expired
);

  typedef struct packed {
    logic [l2bw_pkg::WAIT_W-1:0] cnt;
  } l2bw_ctr_s;

  l2bw_ctr_s s_q;
  l2bw_ctr_s s_d;

  always_comb begin
    s_d = s_q;
    if (!req || gnt) begin
      s_d.cnt = '0;
    end else if (s_q.cnt != l2bw_pkg::WAIT_MAX) begin
      s_d.cnt = s_q.cnt + 6'h01;
    end
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign cnt = s_q.cnt;
  // Saturation keeps a starved requester expired until served
  assign expired = req && (thr != '0) && (s_q.cnt >= thr);

endmodule : l2bw_wait_ctr

// ===== src/l2bw_dma_pick.sv
// Purpose: Choose one DMA source and the DMA class priority
// Assumes: Lower number means higher priority
// Notes: Equal sources alternate on the round-robin bit

`timescale 1ns/10ps

module l2bw_dma_pick (
  // Sources
  input wire logic internal_transfer_engine_req,
  input wire logic slave_transfer_port_req,
  input wire logic [l2bw_pkg::PRI_W-1:0] internal_transfer_engine_pri,
  input wire logic [l2bw_pkg::PRI_W-1:0] slave_transfer_port_pri,
  input wire logic internal_transfer_engine_exp,
  input wire logic slave_transfer_port_exp,
  input wire logic rr,
  // Class result
  output logic req,
  output logic pick_slave_transfer_port,
  output logic tie,
  output logic [l2bw_pkg::PRI_W-1:0] pri
);

  always_comb begin
    req = internal_transfer_engine_req || slave_transfer_port_req;
    tie = internal_transfer_engine_req && slave_transfer_port_req && (internal_transfer_engine_pri == slave_transfer_port_pri);
    if (!internal_transfer_engine_req) begin
      pick_slave_transfer_port = slave_transfer_port_req;
    end else if (!slave_transfer_port_req) begin
      pick_slave_transfer_port = 1'b0;
    end else if (internal_transfer_engine_exp != slave_transfer_port_exp) begin
      pick_slave_transfer_port = slave_transfer_port_exp;
    end else if (tie) begin
      pick_slave_transfer_port = rr;
    end else begin
      pick_slave_transfer_port = slave_transfer_port_pri < internal_transfer_engine_pri;
    end
    pri = pick_slave_transfer_port ? slave_transfer_port_pri : internal_transfer_engine_pri;
  end

endmodule : l2bw_dma_pick

// ===== bench/l2bw_req_model.sv
// Purpose: CPU and DMA masters that ask the L2 arbiter for slices
// Assumes: Requests are levels on clk, one slice per high grant cycle
// Notes: Tallies slices and grant collisions for the bench

`timescale 1ns/10ps

module l2bw_req_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bench control
  input wire logic [2:0] want,
  // Arbiter side
  output logic cpu_req,
  output logic internal_transfer_engine_req,
  output logic slave_transfer_port_req,
  input wire logic cpu_gnt,
  input wire logic internal_transfer_engine_gnt,
  input wire logic slave_transfer_port_gnt,
  // Tallies
  output logic [15:0] n_cpu,
  output logic [15:0] n_internal_transfer_engine,
  output logic [15:0] n_slave_transfer_port,
  output logic [15:0] n_clash
);
  // Masters keep asking every cycle; no grace for the arbiter
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      {cpu_req, internal_transfer_engine_req, slave_transfer_port_req} <= 3'h0;
      n_cpu <= 16'h0000;
      n_internal_transfer_engine <= 16'h0000;
      n_slave_transfer_port <= 16'h0000;
      n_clash <= 16'h0000;
    end else begin
      {slave_transfer_port_req, internal_transfer_engine_req, cpu_req} <= want;
      n_cpu <= n_cpu + {15'h0000, cpu_gnt};
      n_internal_transfer_engine <= n_internal_transfer_engine + {15'h0000, internal_transfer_engine_gnt};
      n_slave_transfer_port <= n_slave_transfer_port + {15'h0000, slave_transfer_port_gnt};
      if ((2'(cpu_gnt) + 2'(internal_transfer_engine_gnt) + 2'(slave_transfer_port_gnt)) > 2'h1) begin
        n_clash <= n_clash + 16'h0001;
      end
    end
  end
endmodule : l2bw_req_model

// ===== bench/testbench.sv
// Purpose: Self-checking bench of the L2 bandwidth arbiter
// Assumes: Zero-wait AHB-Lite slave, requests from l2bw_req_model
// Notes: Slice counts are taken over fixed request windows

`timescale 1ns/10ps

module testbench;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [2:0] want = 3'h0;
  logic slave_transfer_port_mst = 1'b0;
  logic slave_transfer_port_done = 1'b0;
  logic [31:0] hrdata;
  logic hreadyout;
  logic [1:0] hresp;
  logic cpu_req, internal_transfer_engine_req, slave_transfer_port_req, cpu_gnt, internal_transfer_engine_gnt, slave_transfer_port_gnt;
  logic [15:0] n_cpu, n_internal_transfer_engine, n_slave_transfer_port, n_clash;
  logic [15:0] dc, di, ds;
  logic [31:0] rd;
  int fail_count = 0;
  int samples_checked = 0;

  always #2.5 clk = ~clk;

  l2bw_arbiter i_l2bw_arbiter (
    .CLK(clk), .RST(rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite),
    .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout),
    .HRESP(hresp), .CPU_REQ(cpu_req), .INTERNAL_TRANSFER_ENGINE_REQ(internal_transfer_engine_req), .SLAVE_TRANSFER_PORT_REQ(slave_transfer_port_req),
    .SLAVE_TRANSFER_PORT_MST(slave_transfer_port_mst), .SLAVE_TRANSFER_PORT_DONE(slave_transfer_port_done), .CPU_GNT(cpu_gnt), .INTERNAL_TRANSFER_ENGINE_GNT(internal_transfer_engine_gnt),
    .SLAVE_TRANSFER_PORT_GNT(slave_transfer_port_gnt)
  );

  l2bw_req_model i_l2bw_req_model (
    .clk(clk), .rst(rst), .want(want), .cpu_req(cpu_req), .internal_transfer_engine_req(internal_transfer_engine_req),
    .slave_transfer_port_req(slave_transfer_port_req), .cpu_gnt(cpu_gnt), .internal_transfer_engine_gnt(internal_transfer_engine_gnt), .slave_transfer_port_gnt(slave_transfer_port_gnt),
    .n_cpu(n_cpu), .n_internal_transfer_engine(n_internal_transfer_engine), .n_slave_transfer_port(n_slave_transfer_port), .n_clash(n_clash)
  );

  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Ready and read data are taken at the rising edge that ends each phase
  task ahb(input logic wr, input logic [31:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do begin
      @(posedge clk);
    end while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do begin
      @(posedge clk);
    end while (hreadyout !== 1'b1);
    r = hrdata;
  endtask : ahb

  task wr(input logic [31:0] a, input logic [31:0] d);
    logic [31:0] r;
    ahb(1'b1, a, d, r);
  endtask : wr

  task rchk(input string what, input logic [31:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0000_0000, rd);
    check(what, rd, exp);
  endtask : rchk

  task window(input logic [2:0] w, input int n);
    logic [15:0] c0, i0, s0;
    c0 = n_cpu;
    i0 = n_internal_transfer_engine;
    s0 = n_slave_transfer_port;
    want <= w;
    repeat (n) @(posedge clk);
    want <= 3'h0;
    repeat (3) @(posedge clk);
    dc = n_cpu - c0;
    di = n_internal_transfer_engine - i0;
    ds = n_slave_transfer_port - s0;
  endtask : window

  task test_done;
    $display("Checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : test_done

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("ERROR watchdog expected finish seen hang");
    test_done();
  end

  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    rchk("cpu_arb", l2bw_pkg::ADDR_CPU_ARB, l2bw_pkg::RST_CPU_ARB);
    rchk("dma_arb", l2bw_pkg::ADDR_DMA_ARB, l2bw_pkg::RST_DMA_ARB);
    rchk("count", l2bw_pkg::ADDR_CNT, l2bw_pkg::RST_CNT);
    rchk("mst0", l2bw_pkg::ADDR_MST0, l2bw_pkg::RST_MST);
    rchk("mst1", l2bw_pkg::ADDR_MST1, l2bw_pkg::RST_MST);
    rchk("src", l2bw_pkg::ADDR_SRC, l2bw_pkg::RST_DATA);
    wr(l2bw_pkg::ADDR_DST, 32'hA5A5_5A5A);
    rchk("dst", l2bw_pkg::ADDR_DST, 32'hA5A5_5A5A);
    wr(32'h0184_100C, 32'hFFFF_FFFF);
    rchk("unmapped", 32'h0184_100C, 32'h0000_0000);
    $display("Test registers done");
    // CPU level 1 above engine level 2, no forced slices
    wr(l2bw_pkg::ADDR_CPU_ARB, 32'h0000_0001);
    wr(l2bw_pkg::ADDR_DMA_ARB, 32'h0000_0000);
    window(3'b001, 20);
    check("cpu_alone", {16'h0000, dc}, 32'h0000_0014);
    want <= 3'b011;
    repeat (80) @(posedge clk);
    ahb(1'b0, l2bw_pkg::ADDR_STATUS, 32'h0000_0000, rd);
    check("status_gnt", {29'h0, rd[2:0]}, 32'h0000_0001);
    check("internal_transfer_engine_ctr", {26'h0, rd[21:16]}, 32'h0000_003F);
    check("cpu_ctr", {26'h0, rd[13:8]}, 32'h0000_0000);
    want <= 3'h0;
    repeat (4) @(posedge clk);
    ahb(1'b0, l2bw_pkg::ADDR_STATUS, 32'h0000_0000, rd);
    check("internal_transfer_engine_ctr_clear", {26'h0, rd[21:16]}, 32'h0000_0000);
    $display("Test contention done");
    wr(l2bw_pkg::ADDR_DMA_ARB, 32'h0004_0000);
    window(3'b011, 60);
    check("forced_slices", 32'(di >= 16'd8 && di <= 16'd13), 32'h0000_0001);
    $display("Test threshold done");
    wr(l2bw_pkg::ADDR_DMA_ARB, 32'h0000_0000);
    wr(l2bw_pkg::ADDR_CPU_ARB, 32'h0000_0002);
    window(3'b011, 40);
    check("equal_total", {16'h0000, dc + di}, 32'h0000_0028);
    check("equal_share", 32'(dc - di + 16'd1 <= 16'd2), 32'h0000_0001);
    wr(l2bw_pkg::ADDR_CPU_ARB, 32'h8000_0002);
    wr(l2bw_pkg::ADDR_DMA_ARB, 32'h0004_0000);
    window(3'b011, 40);
    check("defect_starve", {16'h0000, di}, 32'h0000_0000);
    $display("Test sharing done");
    wr(l2bw_pkg::ADDR_CPU_ARB, 32'h0000_0003);
    wr(l2bw_pkg::ADDR_DMA_ARB, 32'h0000_0000);
    wr(l2bw_pkg::ADDR_MST0, 32'h0000_0000);
    window(3'b101, 30);
    check("port_wins", {16'h0000, ds}, 32'h0000_001E);
    slave_transfer_port_done <= 1'b1;
    window(3'b101, 30);
    check("drained_cpu", {16'h0000, dc}, 32'h0000_001E);
    check("drained_port", {16'h0000, ds}, 32'h0000_0000);
    slave_transfer_port_done <= 1'b0;
    wr(l2bw_pkg::ADDR_MST0, 32'h0000_0060);
    slave_transfer_port_mst <= 1'b1;
    window(3'b101, 30);
    check("mst1_port", {16'h0000, ds}, 32'h0000_001E);
    slave_transfer_port_mst <= 1'b0;
    $display("Test slave port done");
    wr(l2bw_pkg::ADDR_MST0, 32'h0000_0020);
    window(3'b110, 40);
    check("dma_total", {16'h0000, di + ds}, 32'h0000_0028);
    check("dma_share", 32'(di - ds + 16'd1 <= 16'd2), 32'h0000_0001);
    check("one_class", {16'h0000, n_clash}, 32'h0000_0000);
    check("hresp", {30'h0, hresp}, 32'h0000_0000);
    $display("Test dma classes done");
    test_done();
  end
endmodule : testbench
